// file: include/fbp_pkg.sv
// Constants, state encoding and register struct for the flyback protection sequencer
package fbp_pkg;

  // Clock rate
  localparam int CLK_HZ = 50_000_000;

  // Startup interval with the higher shutdown threshold, in ms
  localparam int SD_STARTUP_MS = 1;
  localparam logic [15:0] SD_STARTUP_CYC_DEF = 16'(SD_STARTUP_MS * (CLK_HZ / 1000));

  // Shutdown debounce time, in us
  localparam int SD_DEBOUNCE_US = 400;
  localparam logic [15:0] SD_DEBOUNCE_CYC_DEF = 16'(SD_DEBOUNCE_US * (CLK_HZ / 1_000_000));

  // Current sense short window scale: window cycles = scale / (line level + 1)
  localparam logic [15:0] CS_WIN_SCALE_DEF = 16'h0400;

  // Consecutive short cycles tolerated before auto-restart
  localparam logic [1:0] CS_SHORT_LIMIT = 2'h2;

  // Diode short sequence: detected, then one further cycle running
  localparam logic [1:0] DIODE_SEEN = 2'h1;
  localparam logic [1:0] DIODE_LAST = 2'h2;

  // Bit positions of the asynchronous comparator inputs
  localparam int AN_W = 9;
  localparam int AN_SUP_ON = 0;
  localparam int AN_SUP_HV = 1;
  localparam int AN_SD_ST = 2;
  localparam int AN_SD_NORM = 3;
  localparam int AN_CS_LIM = 4;
  localparam int AN_CS_DIODE = 5;
  localparam int AN_CS_LOW = 6;
  localparam int AN_FB_HIGH = 7;
  localparam int AN_FB_LOW = 8;

  typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_RESTART} fbp_state_t;

  typedef struct packed {
    fbp_state_t state;
    logic [AN_W-1:0] s1;
    logic [AN_W-1:0] s2;
    logic [AN_W-1:0] s3;
    logic [AN_W-1:0] filt;
    logic st_active;
    logic [15:0] st_cnt;
    logic sd_cont;
    logic sd_low;
    logic [15:0] sd_cnt;
    logic gate;
    logic [1:0] diode_cnt;
    logic [15:0] win_cnt;
    logic win_hit;
    logic win_bad;
    logic [1:0] short_cnt;
  } fbp_reg_t;

endpackage : fbp_pkg

// file: hw/fbp_protect.sv
// Protection sequencer: shutdown sense, current limits, short detection, auto-restart
`timescale 1ns/10ps
module fbp_protect #(
  parameter logic [15:0] SD_STARTUP_CYC = fbp_pkg::SD_STARTUP_CYC_DEF,
  parameter logic [15:0] SD_DEBOUNCE_CYC = fbp_pkg::SD_DEBOUNCE_CYC_DEF,
  parameter logic [15:0] CS_WIN_SCALE = fbp_pkg::CS_WIN_SCALE_DEF
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic SUPPLY_AT_TURN_ON,
  input wire logic SUPPLY_AT_HV_STARTUP,
  input wire logic SD_BELOW_STARTUP_TH,
  input wire logic SD_BELOW_NORMAL_TH,
  input wire logic CS_AT_LIMIT,
  input wire logic CS_AT_DIODE_SHORT,
  input wire logic CS_BELOW_SHORT,
  input wire logic FB_ABOVE_BURST_HIGH,
  input wire logic FB_BELOW_BURST_LOW,
  input wire logic CYCLE_START,
  input wire logic GATE_DEMAND,
  input wire logic LEB_ACTIVE,
  input wire logic [7:0] LINE_LEVEL,
  output logic GATE_DRIVE,
  output logic AUTO_RESTART,
  output logic STARTUP_TH_SELECT
);

  fbp_pkg::fbp_reg_t r;
  fbp_pkg::fbp_reg_t next_r;

  logic run;
  logic sd_sample;
  logic sd_below;
  logic sd_fault;
  logic diode_fault;
  logic short_fault;
  logic fault_any;
  logic [15:0] win_len;
  logic [fbp_pkg::AN_W-1:0] an_in;
  logic [fbp_pkg::AN_W-1:0] agree;

  assign an_in = {FB_BELOW_BURST_LOW, FB_ABOVE_BURST_HIGH, CS_BELOW_SHORT, CS_AT_DIODE_SHORT,
                  CS_AT_LIMIT, SD_BELOW_NORMAL_TH, SD_BELOW_STARTUP_TH, SUPPLY_AT_HV_STARTUP,
                  SUPPLY_AT_TURN_ON};
  assign agree = ~(r.s2 ^ r.s3);
  assign run = (r.state == fbp_pkg::ST_RUN);
  assign sd_sample = run && (r.sd_cont || CYCLE_START);
  assign sd_below = r.st_active ? r.filt[fbp_pkg::AN_SD_ST] : r.filt[fbp_pkg::AN_SD_NORM];
  assign win_len = 16'(CS_WIN_SCALE / ({8'h00, LINE_LEVEL} + 16'h0001));
  assign sd_fault = run && r.sd_low && (r.sd_cnt == SD_DEBOUNCE_CYC - 16'h0001);
  assign diode_fault = run && CYCLE_START && (r.diode_cnt == fbp_pkg::DIODE_LAST);
  assign short_fault = run && CYCLE_START && r.win_hit && r.win_bad &&
                       (r.short_cnt == fbp_pkg::CS_SHORT_LIMIT);
  assign fault_any = sd_fault || diode_fault || short_fault;

  always_comb begin
    next_r = r;
    // Change counts once the second and third stages agree
    next_r.s1 = an_in;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.filt = (r.s2 & agree) | (r.filt & ~agree);

    // Mode holds inside the burst hysteresis band
    if (r.filt[fbp_pkg::AN_FB_LOW]) begin
      next_r.sd_cont = 1'b1;
    end else if (r.filt[fbp_pkg::AN_FB_HIGH]) begin
      next_r.sd_cont = 1'b0;
    end

    unique case (r.state)
      fbp_pkg::ST_OFF: begin
        if (r.filt[fbp_pkg::AN_SUP_ON]) begin
          next_r.state = fbp_pkg::ST_RUN;
        end
      end
      fbp_pkg::ST_RUN: begin
        if (fault_any) begin
          next_r.state = fbp_pkg::ST_RESTART;
        end
      end
      fbp_pkg::ST_RESTART: begin
        if (r.filt[fbp_pkg::AN_SUP_HV]) begin
          next_r.state = fbp_pkg::ST_OFF;
        end
      end
    endcase

    if (!run) begin
      next_r.st_active = 1'b1;
      next_r.st_cnt = 16'h0000;
      next_r.sd_low = 1'b0;
      next_r.sd_cnt = 16'h0000;
      next_r.gate = 1'b0;
      next_r.diode_cnt = 2'h0;
      next_r.win_cnt = 16'h0000;
      next_r.win_hit = 1'b0;
      next_r.win_bad = 1'b0;
      next_r.short_cnt = 2'h0;
    end else begin
      if (r.st_active) begin
        next_r.st_cnt = r.st_cnt + 16'h0001;
        if (r.st_cnt == SD_STARTUP_CYC - 16'h0001) begin
          next_r.st_active = 1'b0;
        end
      end

      if (sd_sample) begin
        next_r.sd_low = sd_below;
      end
      if (r.sd_low && r.sd_cnt != 16'hFFFF) begin
        next_r.sd_cnt = r.sd_cnt + 16'h0001;
      end else if (!r.sd_low) begin
        next_r.sd_cnt = 16'h0000;
      end

      if (r.filt[fbp_pkg::AN_CS_DIODE] && r.diode_cnt == 2'h0) begin
        next_r.diode_cnt = fbp_pkg::DIODE_SEEN;
      end
      if (CYCLE_START && r.diode_cnt == fbp_pkg::DIODE_SEEN) begin
        next_r.diode_cnt = fbp_pkg::DIODE_LAST;
      end

      if (r.gate && r.win_cnt != 16'h0000) begin
        next_r.win_cnt = r.win_cnt - 16'h0001;
        if (r.win_cnt == 16'h0001) begin
          next_r.win_hit = 1'b1;
          next_r.win_bad = r.filt[fbp_pkg::AN_CS_LOW];
        end
      end
      if (CYCLE_START) begin
        next_r.win_cnt = win_len;
        next_r.win_hit = 1'b0;
        next_r.win_bad = 1'b0;
        // Cycles whose window never closed leave the count as it was
        if (r.win_hit) begin
          next_r.short_cnt = r.win_bad ? r.short_cnt + 2'h1 : 2'h0;
        end
      end

      // Gate: any off condition beats a new cycle start
      if (fault_any) begin
        next_r.gate = 1'b0;
      end else if (r.filt[fbp_pkg::AN_CS_DIODE]) begin
        next_r.gate = 1'b0;
      end else if (r.filt[fbp_pkg::AN_CS_LIM] && !LEB_ACTIVE) begin
        next_r.gate = 1'b0;
      end else if (!GATE_DEMAND) begin
        next_r.gate = 1'b0;
      end else if (CYCLE_START) begin
        next_r.gate = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      r <= '0;
      r.state <= fbp_pkg::ST_OFF;
      r.st_active <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign GATE_DRIVE = r.gate;
  assign AUTO_RESTART = (r.state == fbp_pkg::ST_RESTART);
  assign STARTUP_TH_SELECT = r.st_active;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  property p_startup_th;
    (r.state == fbp_pkg::ST_OFF && r.filt[fbp_pkg::AN_SUP_ON]) |=>
      STARTUP_TH_SELECT && run;
  endproperty
  a_startup_th: assert property (p_startup_th) else $error("startup threshold not used");

  property p_startup_end;
    (run && r.st_active && r.st_cnt == SD_STARTUP_CYC - 16'h0001 && !fault_any) |=>
      !STARTUP_TH_SELECT;
  endproperty
  a_startup_end: assert property (p_startup_end) else $error("threshold not lowered");

  property p_sd_trigger;
    sd_fault |=> AUTO_RESTART;
  endproperty
  a_sd_trigger: assert property (p_sd_trigger) else $error("shutdown not restarted");

  property p_sd_hold;
    (run && !sd_sample) |=> (r.sd_low == $past(r.sd_low)) || !run;
  endproperty
  a_sd_hold: assert property (p_sd_hold) else $error("shutdown sampled off pace");

  property p_sd_debounce;
    (run && $rose(r.sd_low)) |=> !AUTO_RESTART;
  endproperty
  a_sd_debounce: assert property (p_sd_debounce) else $error("debounce skipped");

  property p_cs_limit;
    (r.filt[fbp_pkg::AN_CS_LIM] && !LEB_ACTIVE) |=> !GATE_DRIVE;
  endproperty
  a_cs_limit: assert property (p_cs_limit) else $error("gate on past limit");

  property p_diode_off;
    r.filt[fbp_pkg::AN_CS_DIODE] |=> !GATE_DRIVE;
  endproperty
  a_diode_off: assert property (p_diode_off) else $error("gate on past diode short");

  property p_diode_restart;
    (run && CYCLE_START && r.diode_cnt == fbp_pkg::DIODE_LAST) |=> AUTO_RESTART;
  endproperty
  a_diode_restart: assert property (p_diode_restart) else $error("diode short no restart");

  property p_short_restart;
    short_fault |=> AUTO_RESTART && !GATE_DRIVE;
  endproperty
  a_short_restart: assert property (p_short_restart) else $error("cs short no restart");

  property p_restart_off;
    AUTO_RESTART |-> !GATE_DRIVE;
  endproperty
  a_restart_off: assert property (p_restart_off) else $error("gate on in restart");

  property p_release;
    (AUTO_RESTART && r.filt[fbp_pkg::AN_SUP_HV]) |=> !AUTO_RESTART && !run;
  endproperty
  a_release: assert property (p_release) else $error("restart not released");

  property p_clear;
    !run |=> r.sd_cnt == 16'h0000 && r.short_cnt == 2'h0 && r.diode_cnt == 2'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("counters not cleared");

endmodule : fbp_protect

// file: verif/fbp_cs_model.sv
// Current sense network model: ramp seen on the sense pin while the gate conducts
`timescale 1ns/10ps
module fbp_cs_model (
  input wire logic CLK,
  input wire logic GATE_DRIVE,
  input wire logic [1:0] mode,
  output logic CS_AT_LIMIT,
  output logic CS_AT_DIODE_SHORT,
  output logic CS_BELOW_SHORT
);
  int on_cnt = 0;
  always @(posedge CLK) begin
    on_cnt <= GATE_DRIVE ? on_cnt + 1 : 0;
  end
  // Mode 0 ramps to the limit, mode 1 is a shorted diode, mode 2 a shorted sense pin
  assign CS_AT_LIMIT = (mode == 2'h0) && (on_cnt >= 8);
  assign CS_AT_DIODE_SHORT = (mode == 2'h1) && (on_cnt >= 2);
  assign CS_BELOW_SHORT = (mode == 2'h2) || (on_cnt < 1);
endmodule : fbp_cs_model

// file: verif/test_flyback_fault_protection_logic.sv
// Self-checking bench for the protection sequencer
`timescale 1ns/10ps
module test_flyback_fault_protection_logic;
  logic CLK = 1'b0, SYS_RST = 1'b1, TURN_ON = 1'b0, HV = 1'b0, SD_LOW = 1'b0;
  logic CYC = 1'b0, DEMAND = 1'b0, LEB = 1'b0;
  logic FB_HI = 1'b0, FB_LO = 1'b1, SD_ST = 1'b0;
  logic [7:0] LINE = 8'h00;
  logic [1:0] mode = 2'h0;
  logic LIM, DIODE, BELOW, GATE, AR, STSEL;
  int fail_count = 0, checked = 0, bad = 0;
  always #10 CLK = ~CLK;
  fbp_protect #(.SD_STARTUP_CYC(16'h0028), .SD_DEBOUNCE_CYC(16'h0014),
    .CS_WIN_SCALE(fbp_pkg::CS_WIN_SCALE_DEF)) u_dut (.CLK(CLK), .SYS_RST(SYS_RST),
    .SUPPLY_AT_TURN_ON(TURN_ON), .SUPPLY_AT_HV_STARTUP(HV), .SD_BELOW_STARTUP_TH(SD_ST),
    .SD_BELOW_NORMAL_TH(SD_LOW), .CS_AT_LIMIT(LIM), .CS_AT_DIODE_SHORT(DIODE),
    .CS_BELOW_SHORT(BELOW), .FB_ABOVE_BURST_HIGH(FB_HI), .FB_BELOW_BURST_LOW(FB_LO),
    .CYCLE_START(CYC), .GATE_DEMAND(DEMAND), .LEB_ACTIVE(LEB), .LINE_LEVEL(LINE),
    .GATE_DRIVE(GATE), .AUTO_RESTART(AR), .STARTUP_TH_SELECT(STSEL));
  fbp_cs_model u_cs (.CLK(CLK), .GATE_DRIVE(GATE), .mode(mode), .CS_AT_LIMIT(LIM),
    .CS_AT_DIODE_SHORT(DIODE), .CS_BELOW_SHORT(BELOW));
  task automatic stop_test();
    if (fail_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %b seen %b", name, exp, got);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(negedge CLK);
  endtask : idle
  // One switching cycle of 29 clocks; gate checked shortly after the start
  task automatic pulse_cycle(input logic exp_on);
    @(negedge CLK) CYC = 1'b1;
    @(negedge CLK) CYC = 1'b0;
    idle(1);
    chk("gate_on", exp_on, GATE);
    idle(26);
  endtask : pulse_cycle
  // Bounded wait for the restart latch
  task automatic wait_ar(input int lim);
    int i;
    for (i = 0; i < lim && AR !== 1'b1; i++) idle(1);
    chk("restart", 1'b1, AR);
  endtask : wait_ar
  task automatic release_restart();
    @(negedge CLK) HV = 1'b1;
    TURN_ON = 1'b0;
    idle(10);
    chk("restart_clear", 1'b0, AR);
    HV = 1'b0;
    TURN_ON = 1'b1;
    idle(10);
    chk("startup_th_again", 1'b1, STSEL);
    pulse_cycle(1'b1);
  endtask : release_restart
  initial begin
    #200000;
    fail_count++;
    stop_test();
  end
  initial begin
    int k;
    k = $urandom(32'h0000_ea6c);
    idle(20);
    chk("rst_gate", 1'b0, GATE);
    chk("rst_th", 1'b1, STSEL);
    SYS_RST = 1'b0;
    TURN_ON = 1'b1;
    DEMAND = 1'b1;
    idle(10);
    chk("startup_th", 1'b1, STSEL);
    idle(60);
    chk("normal_th", 1'b0, STSEL);
    // A cycle that runs to the peak limit ends with demand still high
    pulse_cycle(1'b1);
    chk("gate_limit_off", 1'b0, GATE);
    SD_LOW = 1'b1;
    idle(10);
    SD_LOW = 1'b0;
    idle(40);
    chk("short_sd_ignored", 1'b0, AR);
    SD_LOW = 1'b1;
    wait_ar(60);
    SD_LOW = 1'b0;
    pulse_cycle(1'b0);
    release_restart();
    // Diode short caught inside blanking, restart one full cycle later
    mode = 2'h1;
    LEB = 1'b1;
    pulse_cycle(1'b1);
    chk("gate_diode_off", 1'b0, GATE);
    pulse_cycle(1'b1);
    chk("diode_wait", 1'b0, AR);
    pulse_cycle(1'b0);
    chk("diode_restart", 1'b1, AR);
    LEB = 1'b0;
    mode = 2'h2;
    release_restart();
    // Low line gives a window longer than the cycle, so no sample is ever judged
    for (k = 0; k < 5; k++) pulse_cycle(1'b1);
    chk("long_window", 1'b0, AR);
    bad = 0;
    for (k = 1; k <= 5; k++) begin
      @(negedge CLK) LINE = 8'(64 + $urandom % 192);
      // Each cycle start judges the window of the cycle before
      if (k > 1) bad++;
      pulse_cycle(bad <= 2);
      chk("cs_short", bad > 2, AR);
    end
    mode = 2'h0;
    release_restart();
    idle(20);
    chk("normal_th_again", 1'b0, STSEL);
    // Startup comparator no longer counts once the interval is over
    SD_ST = 1'b1;
    idle(40);
    chk("sd_startup_th_ignored", 1'b0, AR);
    SD_ST = 1'b0;
    // Above burst high the shutdown input is looked at only at cycle starts
    FB_LO = 1'b0;
    FB_HI = 1'b1;
    idle(6);
    SD_LOW = 1'b1;
    idle(40);
    chk("sd_per_cycle_hold", 1'b0, AR);
    pulse_cycle(1'b1);
    chk("sd_per_cycle_trip", 1'b1, AR);
    SD_LOW = 1'b0;
    stop_test();
  end
endmodule : test_flyback_fault_protection_logic
